// ### lte_map.svh
// Register offsets, field positions and timing constants of the LIN timeout and error block
`ifndef LTE_MAP_SVH
`define LTE_MAP_SVH
`define LTE_ADDR_GCR1 4'h0
`define LTE_ADDR_GCR2 4'h1
`define LTE_ADDR_FORMAT 4'h2
`define LTE_ADDR_FLAGS 4'h3
`define LTE_ADDR_INTEN 4'h4
`define LTE_ADDR_ID 4'h5
`define LTE_ADDR_MASK 4'h6
`define LTE_ADDR_BAUD 4'h7
`define LTE_ADDR_CTRL 4'h8
`define LTE_ADDR_RXBYTE 4'h9
`define LTE_GCR1_PARITY 2
`define LTE_GCR1_CTYPE 12
`define LTE_GCR1_STOPEXT 13
`define LTE_GCR1_VERSION 14
`define LTE_GCR2_SENDCS 16
`define LTE_GCR2_CMPCS 17
`define LTE_FMT_CHAR_LO 16
`define LTE_FLG_BUSY 3
`define LTE_FLG_TIMEOUT 4
`define LTE_FLG_WAKE1 5
`define LTE_FLG_WAKE3 6
`define LTE_FLG_ID 13
`define LTE_FLG_BIT 24
`define LTE_FLG_PHYS 25
`define LTE_FLG_NRE 26
`define LTE_FLG_CKS 27
`define LTE_FLG_PAR 28
`define LTE_FLG_VALID 29
`define LTE_CTRL_HDR 0
`define LTE_CTRL_DATA 1
`define LTE_CTRL_END 2
`define LTE_CTRL_WAKE 3
`define LTE_CTRL_BITERR 4
`define LTE_CTRL_PHYSERR 5
`define LTE_CTRL_CKBYTE 6
`define LTE_ID_USER_EXT 6'h3e
`define LTE_ID_RES_EXT 6'h3f
`define LTE_ID_RES_FIRST 6'h3c
`define LTE_FRAME_BASE 8'h2c
`define LTE_BITS_PER_BYTE 8'h0a
`define LTE_CKS_GOOD 8'hff
`define LTE_IDLE_BITS 17'h13880
`define LTE_WAKE1_BITS 17'h00096
`define LTE_WAKE3_BITS 17'h1d4c0
`endif

// ### lte_pkg.sv
// Types shared by the LIN timeout and error block
package lte_pkg;
    typedef enum logic [1:0] {
        LTE_IDLE,
        LTE_HEADER,
        LTE_RESPONSE,
        LTE_EXTENDED
    } lte_frame_t;
endpackage : lte_pkg

// ### lte_bit_timer.sv
// Bit-time tick generator and bit-time counter with limit compare
`timescale 1ns/1ps
module lte_bit_timer #(
    parameter int W = 17
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [15:0] baud_div,
    input wire logic restart,
    input wire logic run,
    input wire logic [W-1:0] limit,
    output logic expired
);
    logic [15:0] presc_reg; // Clocks within one bit time
    logic [W-1:0] count_reg; // Whole bit times counted
    logic tick; // One pulse per bit time

    assign tick = run && (presc_reg >= baud_div);

    // Prescaler from the module clock down to bit time
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            presc_reg <= 16'h0000;
        end else if (restart || !run || tick) begin
            presc_reg <= 16'h0000;
        end else begin
            presc_reg <= presc_reg + 16'h0001;
        end
    end

    // Bit-time counter, saturates at the limit
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count_reg <= '0;
        end else if (restart || !run) begin
            count_reg <= '0;
        end else if (tick && !expired) begin
            count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign expired = run && (count_reg >= limit);
endmodule : lte_bit_timer

// ### lte_core.sv
// LIN timeout control, embedded checksum and error detector
`timescale 1ns/1ps
`include "lte_map.svh"
module lte_core #(
    parameter int TW = 17
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic lin_rx,
    output logic cks_send,
    output logic [7:0] cks_byte,
    output logic irq
);
    logic [31:0] gcr1_reg; // Global control one
    logic [31:0] gcr2_reg; // Global control two
    logic [31:0] fmt_reg; // Frame format
    logic [31:0] flags_reg; // Sticky flags
    logic [31:0] inten_reg; // Interrupt enables
    logic [7:0] id_reg; // Node identifier
    logic [7:0] mask_reg; // Acceptance mask
    logic [15:0] baud_reg; // Clocks per bit minus one
    logic [7:0] rxbyte_reg; // Byte from the receiver
    logic [7:0] rxid_reg; // Received identifier
    logic [8:0] sum_reg; // Running checksum
    logic [31:0] rdata_reg; // Read data
    logic rx_prev_reg; // Previous bus level
    logic cks_send_reg; // Checkbyte strobe
    logic [7:0] cks_byte_reg; // Checkbyte value
    lte_pkg::lte_frame_t state_reg; // Frame phase
    logic [1:0] wake_cnt_reg; // Wakeup signals sent
    logic [31:0] set_bits; // Hardware flag events
    logic [31:0] clr_bits; // Software clears
    logic wr_ctrl, hdr_ev, data_ev, end_ev; // Control pulses
    logic [3:0] n_bytes; // Expected data bytes
    logic [TW-1:0] tmin, tmax; // Frame limits in bit times
    logic nre_run, nre_exp, idle_exp, wake_run, wake_exp; // Timer links
    logic [TW-1:0] wake_lim; // Wakeup limit
    logic edge_ev; // Bus transition
    logic enhanced; // Enhanced checksum in use
    logic [8:0] add1; // Sum of running value and byte
    logic [7:0] add_fold; // Carry folded back in
    logic par0, par1, par_bad; // Identifier parity
    logic id_match; // Filter hit

    assign wr_ctrl = reg_wr && (reg_addr == `LTE_ADDR_CTRL);
    assign hdr_ev = wr_ctrl && reg_wdata[`LTE_CTRL_HDR];
    assign data_ev = wr_ctrl && reg_wdata[`LTE_CTRL_DATA];
    assign end_ev = wr_ctrl && reg_wdata[`LTE_CTRL_END];
    assign edge_ev = (lin_rx != rx_prev_reg);

    // Control registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            gcr1_reg <= 32'h00000000;
            gcr2_reg <= 32'h00000000;
            fmt_reg <= 32'h00000000;
            inten_reg <= 32'h00000000;
            id_reg <= 8'h00;
            mask_reg <= 8'h00;
            baud_reg <= 16'h1387;
        end else if (reg_wr) begin
            case (reg_addr)
                `LTE_ADDR_GCR1: gcr1_reg <= reg_wdata;
                `LTE_ADDR_GCR2: gcr2_reg <= reg_wdata;
                `LTE_ADDR_FORMAT: fmt_reg <= reg_wdata;
                `LTE_ADDR_INTEN: inten_reg <= reg_wdata;
                `LTE_ADDR_ID: id_reg <= reg_wdata[7:0];
                `LTE_ADDR_MASK: mask_reg <= reg_wdata[7:0];
                `LTE_ADDR_BAUD: baud_reg <= reg_wdata[15:0];
                default: begin
                end
            endcase
        end else begin
            // Action bits self clear
            gcr1_reg[`LTE_GCR1_STOPEXT] <= 1'b0;
            gcr2_reg[`LTE_GCR2_SENDCS] <= 1'b0;
            gcr2_reg[`LTE_GCR2_CMPCS] <= 1'b0;
        end
    end

    // Received byte and identifier capture
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rxbyte_reg <= 8'h00;
            rxid_reg <= 8'h00;
            rx_prev_reg <= 1'b1;
        end else begin
            rx_prev_reg <= lin_rx;
            if (reg_wr && reg_addr == `LTE_ADDR_RXBYTE) begin
                rxbyte_reg <= reg_wdata[7:0];
            end
            if (hdr_ev) begin
                rxid_reg <= rxbyte_reg;
            end
        end
    end

    // Identifier checks
    assign par0 = rxid_reg[0] ^ rxid_reg[1] ^ rxid_reg[2] ^ rxid_reg[4];
    assign par1 = ~(rxid_reg[1] ^ rxid_reg[3] ^ rxid_reg[4] ^ rxid_reg[5]);
    assign par_bad = gcr1_reg[`LTE_GCR1_PARITY] && ((par0 != rxid_reg[6]) || (par1 != rxid_reg[7]));
    assign id_match = ((rxid_reg ^ id_reg) & ~mask_reg) == 8'h00;
    // Reserved ids force classic
    assign enhanced = gcr1_reg[`LTE_GCR1_CTYPE] && (rxid_reg[5:0] < `LTE_ID_RES_FIRST);

    // Frame length
    always_comb begin
        n_bytes = 4'h2;
        if (gcr1_reg[`LTE_GCR1_VERSION]) begin
            n_bytes = {1'b0, fmt_reg[`LTE_FMT_CHAR_LO +: 3]} + 4'h1;
        end else begin
            case (rxid_reg[5:4])
                2'b10: n_bytes = 4'h4;
                2'b11: n_bytes = 4'h8;
                default: n_bytes = 4'h2;
            endcase
        end
    end
    assign tmin = TW'(`LTE_FRAME_BASE) + TW'(n_bytes) * TW'(`LTE_BITS_PER_BYTE);
    assign tmax = TW'(((tmin + TW'(1)) * TW'(14)) / TW'(10));

    // Frame phase tracking
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= lte_pkg::LTE_IDLE;
        end else begin
            case (state_reg)
                lte_pkg::LTE_IDLE: if (hdr_ev) state_reg <= lte_pkg::LTE_HEADER;
                lte_pkg::LTE_HEADER: begin
                    if (rxid_reg[5:0] == `LTE_ID_USER_EXT) begin
                        state_reg <= lte_pkg::LTE_EXTENDED;
                    end else begin
                        state_reg <= lte_pkg::LTE_RESPONSE;
                    end
                end
                lte_pkg::LTE_RESPONSE: begin
                    // A new header restarts an unfinished normal frame
                    if (hdr_ev) begin
                        state_reg <= lte_pkg::LTE_HEADER;
                    end else if (end_ev || nre_exp) begin
                        state_reg <= lte_pkg::LTE_IDLE;
                    end
                end
                lte_pkg::LTE_EXTENDED: begin
                    // Extended frame ends only on software stop
                    if (gcr1_reg[`LTE_GCR1_STOPEXT]) state_reg <= lte_pkg::LTE_IDLE;
                end
                default: state_reg <= lte_pkg::LTE_IDLE;
            endcase
        end
    end

    // No timeout for extended identifiers
    assign nre_run = (state_reg == lte_pkg::LTE_RESPONSE)
        && (rxid_reg[5:0] != `LTE_ID_USER_EXT) && (rxid_reg[5:0] != `LTE_ID_RES_EXT);

    // Response timer from header start
    lte_bit_timer #(.W(TW)) u_nre (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .baud_div(baud_reg),
        .restart(hdr_ev),
        .run(nre_run || state_reg == lte_pkg::LTE_HEADER),
        .limit(tmax),
        .expired(nre_exp)
    );

    // Bus idle timer, restarted by any edge
    lte_bit_timer #(.W(TW)) u_idle (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .baud_div(baud_reg),
        .restart(edge_ev),
        .run(1'b1),
        .limit(TW'(`LTE_IDLE_BITS)),
        .expired(idle_exp)
    );

    // Wakeup counting
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wake_cnt_reg <= 2'h0;
            wake_run <= 1'b0;
        end else if (hdr_ev) begin
            wake_cnt_reg <= 2'h0;
            wake_run <= 1'b0;
        end else if (wr_ctrl && reg_wdata[`LTE_CTRL_WAKE]) begin
            wake_run <= 1'b1;
            wake_cnt_reg <= (wake_cnt_reg == 2'h3) ? 2'h1 : wake_cnt_reg + 2'h1;
        end else if (wake_exp) begin
            wake_run <= 1'b0;
        end
    end
    assign wake_lim = (wake_cnt_reg == 2'h3) ? TW'(`LTE_WAKE3_BITS) : TW'(`LTE_WAKE1_BITS);

    // Wait for master header after wakeup
    lte_bit_timer #(.W(TW)) u_wake (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .baud_div(baud_reg),
        .restart(wr_ctrl && reg_wdata[`LTE_CTRL_WAKE]),
        .run(wake_run),
        .limit(wake_lim),
        .expired(wake_exp)
    );

    // Checksum accumulation with end-around carry
    assign add1 = {1'b0, sum_reg[7:0]} + {1'b0, rxbyte_reg};
    assign add_fold = add1[7:0] + {7'h00, add1[8]};
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sum_reg <= 9'h000;
        end else if (hdr_ev) begin
            sum_reg <= 9'h000;
        end else if (state_reg == lte_pkg::LTE_HEADER) begin
            sum_reg <= enhanced ? {1'b0, rxid_reg} : 9'h000;
        end else if (data_ev) begin
            sum_reg <= {1'b0, add_fold};
        end else if (gcr2_reg[`LTE_GCR2_CMPCS]) begin
            sum_reg <= 9'h000;
        end
    end

    // Embedded checkbyte strobe for the transmitter
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cks_send_reg <= 1'b0;
            cks_byte_reg <= 8'h00;
        end else begin
            cks_send_reg <= reg_wr && reg_addr == `LTE_ADDR_GCR2
                && reg_wdata[`LTE_GCR2_SENDCS] && state_reg == lte_pkg::LTE_EXTENDED;
            cks_byte_reg <= ~sum_reg[7:0];
        end
    end
    assign cks_send = cks_send_reg;
    assign cks_byte = cks_byte_reg;

    // Flag events
    always_comb begin
        set_bits = 32'h00000000;
        set_bits[`LTE_FLG_ID] = (state_reg == lte_pkg::LTE_HEADER)
            && rxid_reg[5:0] == `LTE_ID_USER_EXT && id_match && !par_bad;
        set_bits[`LTE_FLG_NRE] = nre_run && nre_exp;
        set_bits[`LTE_FLG_TIMEOUT] = idle_exp;
        set_bits[`LTE_FLG_WAKE1] = wake_exp && wake_cnt_reg != 2'h3;
        set_bits[`LTE_FLG_WAKE3] = wake_exp && wake_cnt_reg == 2'h3;
        set_bits[`LTE_FLG_PAR] = (state_reg == lte_pkg::LTE_HEADER) && par_bad;
        set_bits[`LTE_FLG_BIT] = wr_ctrl && reg_wdata[`LTE_CTRL_BITERR];
        set_bits[`LTE_FLG_PHYS] = wr_ctrl && reg_wdata[`LTE_CTRL_PHYSERR];
        set_bits[`LTE_FLG_CKS] = (gcr2_reg[`LTE_GCR2_CMPCS] && data_ev == 1'b0
            && sum_reg[7:0] != `LTE_CKS_GOOD)
            || (end_ev && add_fold != `LTE_CKS_GOOD);
        set_bits[`LTE_FLG_VALID] = end_ev && state_reg == lte_pkg::LTE_RESPONSE
            && ((flags_reg & 32'h1c000000) == 32'h00000000) && !par_bad
            && add_fold == `LTE_CKS_GOOD;
    end
    assign clr_bits = (reg_wr && reg_addr == `LTE_ADDR_FLAGS) ? reg_wdata : 32'h00000000;

    // Sticky flags, set beats clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flags_reg <= 32'h00000000;
        end else begin
            flags_reg <= (flags_reg & ~clr_bits & ~(hdr_ev ? 32'h3f000000 : 32'h0)) | set_bits;
        end
    end

    // Interrupt from enabled flags, one cycle late
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags_reg & inten_reg);
        end
    end

    // Read port, data one cycle later
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `LTE_ADDR_GCR1: rdata_reg <= gcr1_reg;
                `LTE_ADDR_GCR2: rdata_reg <= gcr2_reg;
                `LTE_ADDR_FORMAT: rdata_reg <= fmt_reg;
                `LTE_ADDR_FLAGS: rdata_reg <= flags_reg
                    | (32'h1 << `LTE_FLG_BUSY) * {31'h0, state_reg != lte_pkg::LTE_IDLE};
                `LTE_ADDR_INTEN: rdata_reg <= inten_reg;
                `LTE_ADDR_ID: rdata_reg <= {16'h0000, rxid_reg, id_reg};
                `LTE_ADDR_MASK: rdata_reg <= {24'h000000, mask_reg};
                `LTE_ADDR_BAUD: rdata_reg <= {16'h0000, baud_reg};
                `LTE_ADDR_RXBYTE: rdata_reg <= {23'h0, sum_reg};
                default: rdata_reg <= 32'h00000000;
            endcase
        end else begin
            rdata_reg <= 32'h00000000;
        end
    end
    assign reg_rdata = rdata_reg;

    // No-response flag only after the limit
    property p_nre_needs_expiry;
        @(posedge clk_sys) disable iff (!resetn)
        $rose(flags_reg[`LTE_FLG_NRE]) |-> $past(nre_exp) && $past(nre_run);
    endproperty
    a_nre_needs_expiry: assert property (p_nre_needs_expiry)
        else $error("no-response flag without expiry");

    // Extended ids never time out
    property p_ext_no_nre;
        @(posedge clk_sys) disable iff (!resetn)
        (rxid_reg[5:0] == `LTE_ID_USER_EXT || rxid_reg[5:0] == `LTE_ID_RES_EXT) |-> !nre_run;
    endproperty
    a_ext_no_nre: assert property (p_ext_no_nre)
        else $error("timeout running for extended id");

    // Limits from the formula
    property p_tmax_one;
        @(posedge clk_sys) disable iff (!resetn)
        (n_bytes == 4'h1) |-> (tmin == TW'(54)) && (tmax == TW'(77));
    endproperty
    a_tmax_one: assert property (p_tmax_one)
        else $error("frame limit wrong for one byte");

    property p_tmax_eight;
        @(posedge clk_sys) disable iff (!resetn)
        (n_bytes == 4'h8) |-> (tmin == TW'(124)) && (tmax == TW'(175));
    endproperty
    a_tmax_eight: assert property (p_tmax_eight)
        else $error("frame limit wrong for eight bytes");

    // Length coding for old versions
    property p_len_code;
        @(posedge clk_sys) disable iff (!resetn)
        !gcr1_reg[`LTE_GCR1_VERSION] && rxid_reg[5:4] == 2'b01 |-> n_bytes == 4'h2;
    endproperty
    a_len_code: assert property (p_len_code)
        else $error("length coding wrong");

    // Reserved ids classic
    property p_reserved_classic;
        @(posedge clk_sys) disable iff (!resetn)
        rxid_reg[5:0] >= `LTE_ID_RES_FIRST |-> !enhanced;
    endproperty
    a_reserved_classic: assert property (p_reserved_classic)
        else $error("enhanced checksum on reserved id");

    // Checkbyte strobe only in extended frames
    property p_cks_ext;
        @(posedge clk_sys) disable iff (!resetn)
        cks_send |-> $past(state_reg) == lte_pkg::LTE_EXTENDED;
    endproperty
    a_cks_ext: assert property (p_cks_ext)
        else $error("checkbyte outside extended frame");

    // Interrupt follows enabled flags
    property p_irq;
        @(posedge clk_sys) disable iff (!resetn)
        ##1 irq == |($past(flags_reg) & $past(inten_reg));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt does not follow flags");

    // Valid frame implies no checksum error
    property p_valid;
        @(posedge clk_sys) disable iff (!resetn)
        set_bits[`LTE_FLG_VALID] |-> !set_bits[`LTE_FLG_CKS];
    endproperty
    a_valid: assert property (p_valid)
        else $error("valid frame with checksum error");
endmodule : lte_core

// ### lte_lin_node.sv
// Behavioural model of another node driving the LIN bus
`timescale 1ns/1ps
module lte_lin_node (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic active,
    output logic lin_rx
);
    // Toggles the bus every clock while active.
    // Falls back to the pulled-up recessive level when quiet.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lin_rx <= 1'b1;
        end else if (active) begin
            lin_rx <= ~lin_rx;
        end else begin
            lin_rx <= 1'b1;
        end
    end
endmodule : lte_lin_node

// ### tb_lin_timeout_and_error_control.sv
// Self-checking testbench of the LIN timeout and error block
`timescale 1ns/1ps
`include "lte_map.svh"
module tb_lin_timeout_and_error_control;
    logic clk_sys, resetn, reg_wr, reg_rd, lin_active, lin_rx, cks_send, irq;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [7:0] cks_byte;
    int errors = 0;
    int samples_checked = 0;
    int cyc = 0;

    // Block under test
    lte_core dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .lin_rx(lin_rx), .cks_send(cks_send), .cks_byte(cks_byte), .irq(irq));
    // Other node on the bus
    lte_lin_node node (.clk_sys(clk_sys), .resetn(resetn), .active(lin_active),
        .lin_rx(lin_rx));

    // Clock at 100 MHz
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Cycle counter for timing checks
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
    end

    task automatic final_report();
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk

    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // Read strobe, data sampled in the following cycle
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask : rd

    // Check one flag bit
    task automatic flag(input int b, input logic e, input string m);
        logic [31:0] d;
        rd(`LTE_ADDR_FLAGS, d);
        chk({31'h0, d[b]}, {31'h0, e}, m);
    endtask : flag

    // Load a byte and fire a frame event
    task automatic byt(input logic [7:0] v, input int c);
        wr(`LTE_ADDR_RXBYTE, {24'h0, v});
        wr(`LTE_ADDR_CTRL, 32'h1 << c);
    endtask : byt

    // Poll a flag and judge the elapsed clocks against the expected figure
    task automatic meas(input int b, input int expc, input int t0, input string m);
        logic [31:0] d;
        d = '0;
        while (d[b] !== 1'b1 && cyc - t0 < expc + 40) rd(`LTE_ADDR_FLAGS, d);
        chk(32'(cyc - t0 >= expc - 3 && cyc - t0 <= expc + 9), 32'h1, m);
        if (d[b] !== 1'b1) final_report();
    endtask : meas

    // Reset values and unmapped space
    task automatic t_regs();
        logic [31:0] d;
        rd(`LTE_ADDR_BAUD, d);
        chk(d, 32'h1387, "baud reset value");
        wr(4'hf, 32'hffffffff);
        rd(4'hf, d);
        chk(d, 32'h0, "unmapped read not zero");
    endtask : t_regs

    // Response timeout for each length source
    task automatic t_nre();
        int ver[6] = '{0, 0, 0, 0, 1, 1};
        int chr[6] = '{0, 0, 0, 0, 0, 7};
        logic [7:0] ids[6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h30, 8'h00};
        int bits[6] = '{91, 91, 119, 175, 77, 175};
        int t0;
        wr(`LTE_ADDR_BAUD, 32'h9);
        for (int i = 0; i < 6; i++) begin
            wr(`LTE_ADDR_GCR1, ver[i] << `LTE_GCR1_VERSION);
            wr(`LTE_ADDR_FORMAT, chr[i] << `LTE_FMT_CHAR_LO);
            byt(ids[i], `LTE_CTRL_HDR);
            t0 = cyc;
            meas(`LTE_FLG_NRE, bits[i] * 10, t0, "no-response time");
        end
        wr(`LTE_ADDR_GCR1, 32'h0);
    endtask : t_nre

    // Extended frames: filter, embedded checkbytes, no timeout
    task automatic t_ext();
        int n;
        wr(`LTE_ADDR_ID, 32'h3e);
        wr(`LTE_ADDR_MASK, 32'h0);
        wr(`LTE_ADDR_INTEN, 32'h1 << `LTE_FLG_ID);
        byt(8'h3e, `LTE_CTRL_HDR);
        flag(`LTE_FLG_ID, 1'b1, "id flag");
        chk({31'h0, irq}, 32'h1, "id interrupt");
        byt(8'h12, `LTE_CTRL_DATA);
        byt(8'h34, `LTE_CTRL_DATA);
        byt(8'hb9, `LTE_CTRL_DATA);
        wr(`LTE_ADDR_GCR2, 32'h1 << `LTE_GCR2_CMPCS);
        flag(`LTE_FLG_CKS, 1'b0, "good embedded sum flagged");
        byt(8'h12, `LTE_CTRL_DATA);
        byt(8'h34, `LTE_CTRL_DATA);
        wr(`LTE_ADDR_GCR2, 32'h1 << `LTE_GCR2_SENDCS);
        n = 0;
        while (cks_send !== 1'b1 && n < 8) begin
            @(negedge clk_sys);
            n++;
        end
        chk({31'h0, cks_send}, 32'h1, "no checkbyte sent");
        chk({24'h0, cks_byte}, 32'hb9, "checkbyte value");
        byt(8'h01, `LTE_CTRL_DATA);
        wr(`LTE_ADDR_GCR2, 32'h1 << `LTE_GCR2_CMPCS);
        flag(`LTE_FLG_CKS, 1'b1, "bad embedded sum missed");
        repeat (2000) @(posedge clk_sys);
        flag(`LTE_FLG_NRE, 1'b0, "timeout on 0x3e");
        wr(`LTE_ADDR_GCR1, 32'h1 << `LTE_GCR1_STOPEXT);
        wr(`LTE_ADDR_GCR1, 32'h0);
        byt(8'h3f, `LTE_CTRL_HDR);
        repeat (2000) @(posedge clk_sys);
        flag(`LTE_FLG_NRE, 1'b0, "timeout on 0x3f");
        wr(`LTE_ADDR_GCR1, 32'h1 << `LTE_GCR1_STOPEXT);
        wr(`LTE_ADDR_INTEN, 32'h0);
    endtask : t_ext

    // Frame checksums of each type, validity and parity
    task automatic t_cks();
        int ct[4] = '{0, 0, 1, 1};
        logic [7:0] ids[4] = '{8'h00, 8'h00, 8'h05, 8'h3c};
        logic [7:0] ck[4] = '{8'hee, 8'hef, 8'he9, 8'hee};
        logic [3:0] bad = 4'b0010;
        logic [31:0] d;
        for (int i = 0; i < 4; i++) begin
            wr(`LTE_ADDR_GCR1, ct[i] << `LTE_GCR1_CTYPE);
            byt(ids[i], `LTE_CTRL_HDR);
            byt(8'hf0, `LTE_CTRL_DATA);
            byt(8'h20, `LTE_CTRL_DATA);
            byt(ck[i], `LTE_CTRL_END);
            rd(`LTE_ADDR_FLAGS, d);
            chk({31'h0, d[`LTE_FLG_CKS]}, {31'h0, bad[i]}, "checksum flag");
            chk({31'h0, d[`LTE_FLG_VALID]}, {31'h0, ~bad[i]}, "valid flag");
        end
        repeat (2000) @(posedge clk_sys);
        flag(`LTE_FLG_NRE, 1'b0, "timeout after complete frame");
        wr(`LTE_ADDR_GCR1, 32'h1 << `LTE_GCR1_PARITY);
        byt(8'h80, `LTE_CTRL_HDR);
        flag(`LTE_FLG_PAR, 1'b0, "good parity flagged");
        byt(8'h00, `LTE_CTRL_HDR);
        flag(`LTE_FLG_PAR, 1'b1, "bad parity missed");
        wr(`LTE_ADDR_GCR1, 32'h0);
    endtask : t_cks

    // Bit and bus errors: flag, interrupt, mask, clear
    task automatic t_err();
        int c[2] = '{`LTE_CTRL_BITERR, `LTE_CTRL_PHYSERR};
        int f[2] = '{`LTE_FLG_BIT, `LTE_FLG_PHYS};
        for (int i = 0; i < 2; i++) begin
            wr(`LTE_ADDR_INTEN, 32'h1 << f[i]);
            wr(`LTE_ADDR_CTRL, 32'h1 << c[i]);
            flag(f[i], 1'b1, "error flag");
            chk({31'h0, irq}, 32'h1, "error interrupt");
            wr(`LTE_ADDR_INTEN, 32'h0);
            repeat (2) @(negedge clk_sys);
            chk({31'h0, irq}, 32'h0, "masked interrupt");
            wr(`LTE_ADDR_FLAGS, 32'h1 << f[i]);
            flag(f[i], 1'b0, "flag not cleared");
        end
    endtask : t_err

    // Wakeup and bus idle timeouts
    task automatic t_idle();
        int t0;
        wr(`LTE_ADDR_CTRL, 32'h1 << `LTE_CTRL_WAKE);
        t0 = cyc;
        meas(`LTE_FLG_WAKE1, 1500, t0, "wakeup timeout");
        wr(`LTE_ADDR_BAUD, 32'h0);
        lin_active <= 1'b1;
        repeat (20) @(posedge clk_sys);
        lin_active <= 1'b0;
        t0 = cyc;
        meas(`LTE_FLG_TIMEOUT, 80000, t0, "bus idle timeout");
    endtask : t_idle

    // Main sequence
    initial begin
        resetn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        lin_active = 1'b0;
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        t_regs();
        t_nre();
        t_ext();
        t_cks();
        t_err();
        t_idle();
        final_report();
    end
endmodule : tb_lin_timeout_and_error_control
